// File: rtl/ocp_pkg.sv
package ocp_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_NS = 10;
	localparam int CLK_HZ = 1_000_000_000 / CLK_NS;
	localparam int TICK_NS = 1_000_000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam int MS_PER_S = 1000;
	localparam int TICKS_PER_S = MS_PER_S * 1_000_000 / TICK_NS;
	localparam int REMIND_S = 300;
	localparam int REMIND_TICKS = REMIND_S * TICKS_PER_S;
	localparam int DIR_MS = 40;
	localparam int DIR_TICKS = DIR_MS * 1_000_000 / TICK_NS;
	localparam int BF_STEP_MS = 100;
	localparam int BF_STEP_TICKS = BF_STEP_MS * 1_000_000 / TICK_NS;
	localparam int SAMP_PER_CYCLE = 32;
	localparam int SAMP50_CYC = CLK_HZ / (50 * SAMP_PER_CYCLE);
	localparam int SAMP60_CYC = CLK_HZ / (60 * SAMP_PER_CYCLE);

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_LS_CFG = 8'h04;
	localparam logic [7:0] ADDR_LS_PICK = 8'h08;
	localparam logic [7:0] ADDR_LS_DLY = 8'h0C;
	localparam logic [7:0] ADDR_HS_PICK = 8'h10;
	localparam logic [7:0] ADDR_HS_DLY = 8'h14;
	localparam logic [7:0] ADDR_ANGLE = 8'h18;
	localparam logic [7:0] ADDR_E_CFG = 8'h1C;
	localparam logic [7:0] ADDR_E_PICK = 8'h20;
	localparam logic [7:0] ADDR_E_DLY = 8'h24;
	localparam logic [7:0] ADDR_BF = 8'h28;
	localparam logic [7:0] ADDR_KEY = 8'h2C;
	localparam logic [7:0] ADDR_STATUS = 8'h30;

	// ****************************************************************
	// Control fields
	// ****************************************************************
	localparam int CTRL_F60 = 0;
	localparam int CTRL_SIN = 1;
	localparam int CTRL_RESISTANCE_EARTHED = 2;
	localparam int CTRL_ETRIP = 3;
	localparam int CTRL_BLK = 4;
	localparam int BLK_LS = 0;
	localparam int BLK_HS = 1;
	localparam int BLK_EL = 2;
	localparam int BLK_EH = 3;
	localparam int BLK_BF = 4;

	// ****************************************************************
	// Reset values and limits
	// ****************************************************************
	localparam logic [8:0] CTRL_RST = 9'h020;
	localparam logic [15:0] PICK_RST = 16'h0064;
	localparam logic [15:0] HS_PICK_RST = 16'h01F4;
	localparam logic [15:0] DLY_RST = 16'h03E8;
	localparam logic [15:0] RES_THR_RST = 16'h000A;
	localparam logic [2:0] ANGLE_RST = 3'h3;
	localparam logic [3:0] BF_CODE_RST = 4'h0;
	localparam logic [7:0] HOLD_RST = 8'h00;
	localparam logic [15:0] DLY_MAX = 16'hEA60;
	localparam logic [15:0] HS_PICK_MAX = 16'h0FA0;
	localparam logic [15:0] FAST_DEF_DLY = 16'h001E;
	localparam logic [15:0] FAST_INV_DLY = 16'h0032;
	localparam logic [15:0] BF_I_MIN = 16'h0001;
	localparam logic [23:0] E_PCT_SCALE = 24'h00_0064;

	typedef enum logic [1:0] {
		definite_curve,
		normal_inverse_curve,
		very_inverse_curve,
		extremely_inverse_curve
	} ocp_curve_t;

endpackage

// File: rtl/ocp_timer.sv
`timescale 1ns/10ps
`default_nettype none
module ocp_timer (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_tick,
	input wire logic i_run,
	input wire logic [7:0] i_inc,
	input wire logic [15:0] i_target,
	input wire logic [17:0] i_hold,
	output logic o_expired
);

	typedef struct packed {
		logic active;
		logic [23:0] acc;
		logic [17:0] hold_cnt;
		logic [15:0] tgt;
	} ocp_tmr_t;

	ocp_tmr_t s_ff;
	ocp_tmr_t nxt;

	assign o_expired = s_ff.active && (s_ff.acc >= {8'h00, s_ff.tgt});

	always_comb begin
		nxt = s_ff;
		if (i_run) begin
			nxt.hold_cnt = '0;
			if (!s_ff.active) begin
				// Target is frozen at start; later stores never touch it
				nxt.active = 1'b1;
				nxt.tgt = i_target;
				nxt.acc = '0;
			end else if (i_tick && !o_expired) begin
				nxt.acc = s_ff.acc + {16'h0000, i_inc};
			end
		end else if (s_ff.active) begin
			if (i_hold == '0) begin
				nxt.active = 1'b0;
				nxt.acc = '0;
			end else if (i_tick) begin
				if (s_ff.hold_cnt + 18'd1 >= i_hold) begin
					nxt.active = 1'b0;
					nxt.acc = '0;
					nxt.hold_cnt = '0;
				end else begin
					nxt.hold_cnt = s_ff.hold_cnt + 18'd1;
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_ff <= '0;
		end else if (i_ce) begin
			s_ff <= nxt;
		end
	end

endmodule
`default_nettype wire

// File: rtl/ocp_trip_logic.sv
`timescale 1ns/10ps
`default_nettype none
module ocp_trip_logic #(
	parameter int P_TICK_CYC = ocp_pkg::TICK_CYC,
	parameter int P_REMIND_TICKS = ocp_pkg::REMIND_TICKS,
	parameter int P_SAMP50_CYC = ocp_pkg::SAMP50_CYC,
	parameter int P_SAMP60_CYC = ocp_pkg::SAMP60_CYC,
	// Arbitrary value
	parameter logic [31:0] P_PASSWORD = 32'h0000_1234,
	parameter bit P_DIRECTIONAL = 1'b1,
	parameter bit P_RESIDUAL = 1'b1,
	parameter bit P_SENSITIVE = 1'b0
) (
	input wire logic I_REF_CLK,
	input wire logic I_RST_N,
	input wire logic I_CE,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic [15:0] I_CUR_L1,
	input wire logic [15:0] I_CUR_L2,
	input wire logic [15:0] I_CUR_L3,
	input wire logic [15:0] I_CUR_E,
	input wire logic [15:0] I_RES_VOLT,
	input wire logic I_FWD_FAULT,
	input wire logic I_EXT_BLOCK,
	output logic O_LS_ALARM,
	output logic O_LS_TRIP,
	output logic O_HS_ALARM,
	output logic O_HS_TRIP,
	output logic O_E_ALARM,
	output logic O_E_TRIP,
	output logic O_BF_RELAY,
	output logic O_TRIP_STORE,
	output logic O_LS_DLY_FLASH,
	output logic O_E_DLY_FLASH,
	output logic O_FREQ_60,
	output logic O_SAMPLE_STB,
	output logic [6:0] O_CHAR_ANGLE,
	output logic O_EARTH_SIN,
	output logic O_EARTH_RESIST
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [8:0] ctrl;
		ocp_pkg::ocp_curve_t [1:0] chr;
		logic [1:0][7:0] hold_s;
		logic [1:0] remind;
		logic [1:0] chr_chg;
		logic [1:0][18:0] rem_cnt;
		logic [15:0] ls_pick;
		logic [15:0] ls_fwd;
		logic [15:0] ls_rev;
		logic [15:0] hs_pick;
		logic [15:0] hs_fwd;
		logic [15:0] hs_rev;
		logic [15:0] res_thr;
		logic [15:0] el_pick;
		logic [15:0] eh_pick;
		logic [15:0] el_dly;
		logic [15:0] eh_dly;
		logic [2:0] angle;
		logic [3:0] bf_code;
		logic unlocked;
		logic [16:0] tick_cnt;
		logic tick;
		logic [5:0] dir_cnt;
		logic bf_armed;
		logic [10:0] bf_cnt;
		logic bf_relay;
		logic [16:0] samp_cnt;
		logic samp_stb;
		logic [5:0] rly;
		logic trip_store;
		logic [31:0] rdata;
		logic rerr;
	} ocp_state_t;

	ocp_state_t s_ff;
	ocp_state_t nxt;

	localparam logic [16:0] TICK_LAST = 17'(P_TICK_CYC - 1);
	localparam logic [18:0] REMIND_LAST = 19'(P_REMIND_TICKS - 1);
	localparam logic [16:0] SAMP50_LAST = 17'(P_SAMP50_CYC - 1);
	localparam logic [16:0] SAMP60_LAST = 17'(P_SAMP60_CYC - 1);
	localparam logic [5:0] DIR_DONE = 6'(ocp_pkg::DIR_TICKS);
	localparam logic [10:0] BF_STEP = 11'(ocp_pkg::BF_STEP_TICKS);
	localparam logic [17:0] HOLD_SCALE = 18'(ocp_pkg::TICKS_PER_S);

	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic logic dly_bad(input logic [15:0] d);
		dly_bad = (d == '0) || (d > ocp_pkg::DLY_MAX);
	endfunction

	function automatic logic [15:0] fast_dly(input ocp_pkg::ocp_curve_t c);
		fast_dly = (c == ocp_pkg::definite_curve) ? ocp_pkg::FAST_DEF_DLY
			: ocp_pkg::FAST_INV_DLY;
	endfunction

	// Coarse current multiple raised to the curve steepness
	function automatic logic [7:0] curve_inc(input ocp_pkg::ocp_curve_t c,
		input logic [23:0] i, input logic [23:0] p);
		logic [7:0] m;
		m = 8'd1 + 8'({1'b0, i} >= {p, 1'b0}) + 8'({2'b0, i} >= {p, 2'b0})
			+ 8'({3'b0, i} >= {p, 3'b0});
		unique case (c)
			ocp_pkg::definite_curve: curve_inc = 8'd1;
			ocp_pkg::normal_inverse_curve: curve_inc = m;
			ocp_pkg::very_inverse_curve: curve_inc = 8'(m * m);
			ocp_pkg::extremely_inverse_curve: curve_inc = 8'(m * m * m);
		endcase
	endfunction

	function automatic logic [15:0] sel_dly(input logic [15:0] f,
		input logic [15:0] r, input logic known, input logic fwd);
		if (!P_DIRECTIONAL || f == r) begin
			sel_dly = f;
		end else if (!known) begin
			sel_dly = (f > r) ? f : r;
		end else begin
			sel_dly = fwd ? f : r;
		end
	endfunction

	function automatic logic [6:0] angle_deg(input logic [2:0] a);
		unique case (a)
			3'd0: angle_deg = 7'd15;
			3'd1: angle_deg = 7'd27;
			3'd2: angle_deg = 7'd38;
			3'd3: angle_deg = 7'd49;
			3'd4: angle_deg = 7'd61;
			3'd5: angle_deg = 7'd72;
			3'd6: angle_deg = 7'd83;
			default: angle_deg = 7'd49;
		endcase
	endfunction

	function automatic logic [23:0] e_thr(input logic [15:0] pick);
		e_thr = P_SENSITIVE ? {8'h00, pick} : 24'(pick * ocp_pkg::E_PCT_SCALE);
	endfunction

	// ****************************************************************
	// Element pickups and enables
	// ****************************************************************
	logic [15:0] imax;
	logic [4:0] blk;
	logic ls_pu, hs_pu, el_pu, eh_pu, e_ok, ls_en, hs_en, dir_known, all_low;
	logic [3:0] t_run, t_exp;
	logic [3:0][7:0] t_inc;
	logic [3:0][15:0] t_tgt;
	logic [3:0][17:0] t_hold;

	assign imax = (I_CUR_L1 > I_CUR_L2) ? ((I_CUR_L1 > I_CUR_L3) ? I_CUR_L1 : I_CUR_L3)
		: ((I_CUR_L2 > I_CUR_L3) ? I_CUR_L2 : I_CUR_L3);
	assign blk = s_ff.ctrl[ocp_pkg::CTRL_BLK +: 5] & {5{I_EXT_BLOCK}};
	assign ls_pu = imax >= s_ff.ls_pick;
	assign hs_pu = imax >= s_ff.hs_pick;
	assign e_ok = !P_RESIDUAL || (I_RES_VOLT > s_ff.res_thr);
	assign el_pu = e_ok && ({8'h00, I_CUR_E} >= e_thr(s_ff.el_pick)) && !blk[ocp_pkg::BLK_EL];
	assign eh_pu = e_ok && ({8'h00, I_CUR_E} >= e_thr(s_ff.eh_pick)) && !blk[ocp_pkg::BLK_EH];
	assign ls_en = !dly_bad(s_ff.ls_fwd) && !(P_DIRECTIONAL && dly_bad(s_ff.ls_rev))
		&& !blk[ocp_pkg::BLK_LS];
	assign hs_en = (s_ff.hs_pick != '0) && (s_ff.hs_pick <= ocp_pkg::HS_PICK_MAX)
		&& !blk[ocp_pkg::BLK_HS];
	assign dir_known = (s_ff.chr[0] == ocp_pkg::definite_curve) || (s_ff.dir_cnt == DIR_DONE);
	assign all_low = (I_CUR_L1 < ocp_pkg::BF_I_MIN) && (I_CUR_L2 < ocp_pkg::BF_I_MIN)
		&& (I_CUR_L3 < ocp_pkg::BF_I_MIN);

	assign t_run = {eh_pu, el_pu, hs_pu && hs_en, ls_pu && ls_en};
	assign t_inc[0] = curve_inc(s_ff.chr[0], {8'h00, imax}, {8'h00, s_ff.ls_pick});
	assign t_inc[1] = 8'd1;
	assign t_inc[2] = curve_inc(s_ff.chr[1], {8'h00, I_CUR_E}, e_thr(s_ff.el_pick));
	assign t_inc[3] = 8'd1;
	assign t_tgt[0] = sel_dly(s_ff.ls_fwd, s_ff.ls_rev, dir_known, I_FWD_FAULT);
	assign t_tgt[1] = sel_dly(s_ff.hs_fwd, s_ff.hs_rev, 1'b1, I_FWD_FAULT);
	assign t_tgt[2] = s_ff.el_dly;
	assign t_tgt[3] = s_ff.eh_dly;
	assign t_hold[0] = (s_ff.chr[0] == ocp_pkg::definite_curve) ? '0
		: 18'(s_ff.hold_s[0] * HOLD_SCALE);
	assign t_hold[1] = '0;
	assign t_hold[2] = (s_ff.chr[1] == ocp_pkg::definite_curve) ? '0
		: 18'(s_ff.hold_s[1] * HOLD_SCALE);
	assign t_hold[3] = '0;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_tmr
			ocp_timer u_tmr (
				.i_clk(I_REF_CLK),
				.i_rst_n(I_RST_N),
				.i_ce(I_CE),
				.i_tick(s_ff.tick),
				.i_run(t_run[g]),
				.i_inc(t_inc[g]),
				.i_target(t_tgt[g]),
				.i_hold(t_hold[g]),
				.o_expired(t_exp[g])
			);
		end
	endgenerate

	// ****************************************************************
	// Next state
	// ****************************************************************
	logic e_exp, any_new, any_old;
	logic [10:0] bf_limit;
	assign e_exp = (t_exp[2] && t_run[2]) || (t_exp[3] && t_run[3]);
	assign any_old = s_ff.rly[1] || s_ff.rly[3] || s_ff.rly[5];
	assign bf_limit = 11'(({7'h00, s_ff.bf_code} + 11'd1) * BF_STEP);

	always_comb begin
		nxt = s_ff;
		any_new = 1'b0;
		if (s_ff.tick_cnt >= TICK_LAST) begin
			nxt.tick_cnt = '0;
			nxt.tick = 1'b1;
		end else begin
			nxt.tick_cnt = s_ff.tick_cnt + 17'd1;
			nxt.tick = 1'b0;
		end
		if (s_ff.samp_cnt >= (s_ff.ctrl[ocp_pkg::CTRL_F60] ? SAMP60_LAST : SAMP50_LAST)) begin
			nxt.samp_cnt = '0;
			nxt.samp_stb = 1'b1;
		end else begin
			nxt.samp_cnt = s_ff.samp_cnt + 17'd1;
			nxt.samp_stb = 1'b0;
		end
		if (!ls_pu) begin
			nxt.dir_cnt = '0;
		end else if (s_ff.tick && s_ff.dir_cnt != DIR_DONE) begin
			nxt.dir_cnt = s_ff.dir_cnt + 6'd1;
		end
		for (int k = 0; k < 2; k++) begin
			if (s_ff.remind[k] && s_ff.tick) begin
				if (s_ff.rem_cnt[k] >= REMIND_LAST) begin
					nxt.remind[k] = 1'b0;
					nxt.chr_chg[k] = 1'b0;
					if (s_ff.chr_chg[k] && k == 0) begin
						nxt.ls_fwd = fast_dly(s_ff.chr[0]);
						nxt.ls_rev = fast_dly(s_ff.chr[0]);
					end else if (s_ff.chr_chg[k]) begin
						nxt.el_dly = fast_dly(s_ff.chr[1]);
					end
				end else begin
					nxt.rem_cnt[k] = s_ff.rem_cnt[k] + 19'd1;
				end
			end
		end
		nxt.rly[0] = ls_pu && !blk[ocp_pkg::BLK_LS];
		nxt.rly[1] = t_exp[0] && t_run[0];
		nxt.rly[2] = hs_pu && hs_en;
		nxt.rly[3] = t_exp[1] && t_run[1];
		nxt.rly[4] = el_pu || eh_pu || (e_exp && !s_ff.ctrl[ocp_pkg::CTRL_ETRIP]);
		nxt.rly[5] = e_exp && s_ff.ctrl[ocp_pkg::CTRL_ETRIP];
		any_new = nxt.rly[1] || nxt.rly[3] || nxt.rly[5];
		nxt.trip_store = any_new && !any_old;
		if (s_ff.bf_armed) begin
			if (all_low) begin
				nxt.bf_armed = 1'b0;
				nxt.bf_relay = 1'b0;
			end else if (s_ff.tick && !s_ff.bf_relay) begin
				if (s_ff.bf_cnt + 11'd1 >= bf_limit) begin
					nxt.bf_relay = 1'b1;
				end
				nxt.bf_cnt = s_ff.bf_cnt + 11'd1;
			end
		end else if (any_new && !any_old && !blk[ocp_pkg::BLK_BF]) begin
			nxt.bf_armed = 1'b1;
			nxt.bf_cnt = '0;
		end
		if (I_PSEL && !I_PENABLE) begin
			nxt.rerr = 1'b0;
			nxt.rdata = '0;
			unique case (I_PADDR)
				ocp_pkg::ADDR_CTRL: nxt.rdata = {23'h00_0000, s_ff.ctrl};
				ocp_pkg::ADDR_LS_CFG: nxt.rdata = {16'h0000, s_ff.hold_s[0], 6'h00, s_ff.chr[0]};
				ocp_pkg::ADDR_LS_PICK: nxt.rdata = {16'h0000, s_ff.ls_pick};
				ocp_pkg::ADDR_LS_DLY: nxt.rdata = {s_ff.ls_rev, s_ff.ls_fwd};
				ocp_pkg::ADDR_HS_PICK: nxt.rdata = {16'h0000, s_ff.hs_pick};
				ocp_pkg::ADDR_HS_DLY: nxt.rdata = {s_ff.hs_rev, s_ff.hs_fwd};
				ocp_pkg::ADDR_ANGLE: nxt.rdata = {29'h0000_0000, s_ff.angle};
				ocp_pkg::ADDR_E_CFG: nxt.rdata = {s_ff.res_thr, s_ff.hold_s[1], 6'h00, s_ff.chr[1]};
				ocp_pkg::ADDR_E_PICK: nxt.rdata = {s_ff.eh_pick, s_ff.el_pick};
				ocp_pkg::ADDR_E_DLY: nxt.rdata = {s_ff.eh_dly, s_ff.el_dly};
				ocp_pkg::ADDR_BF: nxt.rdata = {28'h000_0000, s_ff.bf_code};
				ocp_pkg::ADDR_KEY: nxt.rdata = {31'h0000_0000, s_ff.unlocked};
				ocp_pkg::ADDR_STATUS: nxt.rdata = {22'h00_0000, s_ff.bf_armed, s_ff.remind,
					s_ff.bf_relay, s_ff.rly};
				default: nxt.rerr = 1'b1;
			endcase
		end
		// Stores take effect in one edge; running timers keep their target
		if (I_PSEL && I_PENABLE && I_PWRITE) begin
			unique case (I_PADDR)
				ocp_pkg::ADDR_CTRL: begin
					nxt.ctrl = I_PWDATA[8:0];
					if (!s_ff.unlocked) begin
						nxt.ctrl[ocp_pkg::CTRL_SIN] = s_ff.ctrl[ocp_pkg::CTRL_SIN];
					end
					nxt.unlocked = 1'b0;
				end
				ocp_pkg::ADDR_LS_CFG: begin
					nxt.chr[0] = ocp_pkg::ocp_curve_t'(I_PWDATA[1:0]);
					nxt.hold_s[0] = I_PWDATA[15:8];
					nxt.remind[0] = 1'b1;
					nxt.rem_cnt[0] = '0;
					nxt.chr_chg[0] = s_ff.chr_chg[0] || (I_PWDATA[1:0] != s_ff.chr[0]);
				end
				ocp_pkg::ADDR_LS_PICK: nxt.ls_pick = I_PWDATA[15:0];
				ocp_pkg::ADDR_LS_DLY: begin
					nxt.ls_fwd = I_PWDATA[15:0];
					nxt.ls_rev = P_DIRECTIONAL ? I_PWDATA[31:16] : I_PWDATA[15:0];
					nxt.remind[0] = 1'b0;
					nxt.chr_chg[0] = 1'b0;
				end
				ocp_pkg::ADDR_HS_PICK: nxt.hs_pick = I_PWDATA[15:0];
				ocp_pkg::ADDR_HS_DLY: begin
					nxt.hs_fwd = I_PWDATA[15:0];
					nxt.hs_rev = P_DIRECTIONAL ? I_PWDATA[31:16] : I_PWDATA[15:0];
				end
				ocp_pkg::ADDR_ANGLE: begin
					if (I_PWDATA[2:0] != 3'h7) begin
						nxt.angle = I_PWDATA[2:0];
					end
				end
				ocp_pkg::ADDR_E_CFG: begin
					nxt.chr[1] = ocp_pkg::ocp_curve_t'(I_PWDATA[1:0]);
					nxt.hold_s[1] = I_PWDATA[15:8];
					nxt.res_thr = I_PWDATA[31:16];
					nxt.remind[1] = 1'b1;
					nxt.rem_cnt[1] = '0;
					nxt.chr_chg[1] = s_ff.chr_chg[1] || (I_PWDATA[1:0] != s_ff.chr[1]);
				end
				ocp_pkg::ADDR_E_PICK: begin
					nxt.el_pick = I_PWDATA[15:0];
					nxt.eh_pick = I_PWDATA[31:16];
				end
				ocp_pkg::ADDR_E_DLY: begin
					nxt.el_dly = I_PWDATA[15:0];
					nxt.eh_dly = I_PWDATA[31:16];
					nxt.remind[1] = 1'b0;
					nxt.chr_chg[1] = 1'b0;
				end
				ocp_pkg::ADDR_BF: nxt.bf_code = I_PWDATA[3:0];
				ocp_pkg::ADDR_KEY: nxt.unlocked = (I_PWDATA == P_PASSWORD);
				default: ;
			endcase
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			s_ff <= '0;
			s_ff.ctrl <= ocp_pkg::CTRL_RST;
			s_ff.hold_s <= {ocp_pkg::HOLD_RST, ocp_pkg::HOLD_RST};
			s_ff.ls_pick <= ocp_pkg::PICK_RST;
			s_ff.ls_fwd <= ocp_pkg::DLY_RST;
			s_ff.ls_rev <= ocp_pkg::DLY_RST;
			s_ff.hs_pick <= ocp_pkg::HS_PICK_RST;
			s_ff.hs_fwd <= ocp_pkg::DLY_RST;
			s_ff.hs_rev <= ocp_pkg::DLY_RST;
			s_ff.res_thr <= ocp_pkg::RES_THR_RST;
			s_ff.el_pick <= ocp_pkg::PICK_RST;
			s_ff.eh_pick <= ocp_pkg::HS_PICK_RST;
			s_ff.el_dly <= ocp_pkg::DLY_RST;
			s_ff.eh_dly <= ocp_pkg::DLY_RST;
			s_ff.angle <= ocp_pkg::ANGLE_RST;
			s_ff.bf_code <= ocp_pkg::BF_CODE_RST;
		end else if (I_CE) begin
			s_ff <= nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign O_PRDATA = s_ff.rdata;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = I_PSEL && I_PENABLE && s_ff.rerr;
	assign O_LS_ALARM = s_ff.rly[0];
	assign O_LS_TRIP = s_ff.rly[1];
	assign O_HS_ALARM = s_ff.rly[2];
	assign O_HS_TRIP = s_ff.rly[3];
	assign O_E_ALARM = s_ff.rly[4];
	assign O_E_TRIP = s_ff.rly[5];
	assign O_BF_RELAY = s_ff.bf_relay;
	assign O_TRIP_STORE = s_ff.trip_store;
	assign O_LS_DLY_FLASH = s_ff.remind[0] && s_ff.rem_cnt[0][8];
	assign O_E_DLY_FLASH = s_ff.remind[1] && s_ff.rem_cnt[1][8];
	assign O_FREQ_60 = s_ff.ctrl[ocp_pkg::CTRL_F60];
	assign O_SAMPLE_STB = s_ff.samp_stb;
	assign O_CHAR_ANGLE = angle_deg(s_ff.angle);
	assign O_EARTH_SIN = s_ff.ctrl[ocp_pkg::CTRL_SIN];
	assign O_EARTH_RESIST = s_ff.ctrl[ocp_pkg::CTRL_RESISTANCE_EARTHED];

endmodule
`default_nettype wire

// File: test/ocp_line_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Balanced three-phase source, magnitude per cycle
// ****
module ocp_line_model (
	input wire logic i_clk,
	input wire logic [15:0] i_amp,
	output logic [15:0] o_l1,
	output logic [15:0] o_l2,
	output logic [15:0] o_l3
);
	always_ff @(posedge i_clk) begin
		o_l1 <= i_amp;
		o_l2 <= i_amp;
		o_l3 <= i_amp;
	end
endmodule
`default_nettype wire

// File: test/ocp_trip_logic_bench.sv
`timescale 1ns/10ps
`default_nettype none
module ocp_trip_logic_bench;
	logic clk = 0, rst_n = 0, ce = 1, psel = 0, pen = 0, pwr = 0, blk = 0, fwd = 0, err;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic pready, pslverr, ls_al, ls_tr, hs_al, hs_tr, e_al, e_tr, bf, stb, f60, esin, eres;
	logic lfl, efl;
	logic [15:0] amp = 0, cur_e = 0, resv = 0, l1, l2, l3;
	logic [6:0] ang;
	int errors = 0, samples_checked = 0, t;
	int tbl[7] = '{15, 27, 38, 49, 61, 72, 83};
	always #5 clk = ~clk;
	ocp_line_model ocp_line_model_i (.i_clk(clk), .i_amp(amp), .o_l1(l1), .o_l2(l2), .o_l3(l3));
	ocp_trip_logic #(.P_TICK_CYC(10), .P_REMIND_TICKS(300), .P_SAMP50_CYC(20),
		.P_SAMP60_CYC(16)) ocp_trip_logic_i (
		.I_REF_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_CUR_L1(l1), .I_CUR_L2(l2), .I_CUR_L3(l3),
		.I_CUR_E(cur_e), .I_RES_VOLT(resv), .I_FWD_FAULT(fwd), .I_EXT_BLOCK(blk),
		.O_LS_ALARM(ls_al), .O_LS_TRIP(ls_tr), .O_HS_ALARM(hs_al), .O_HS_TRIP(hs_tr),
		.O_E_ALARM(e_al), .O_E_TRIP(e_tr), .O_BF_RELAY(bf), .O_TRIP_STORE(),
		.O_LS_DLY_FLASH(lfl), .O_E_DLY_FLASH(efl), .O_FREQ_60(f60), .O_SAMPLE_STB(stb),
		.O_CHAR_ANGLE(ang), .O_EARTH_SIN(esin), .O_EARTH_RESIST(eres));
	// ****
	// Tasks
	// ****
	task automatic end_sim;
		$display("errors %0d checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1 && n < 50);
		if (n >= 50) begin
			errors++;
			end_sim();
		end
		q = prdata;
		err = pslverr;
		psel <= 0;
		pen <= 0;
	endtask
	// Waits for a level, bounded; t holds the edges taken
	task automatic wt(ref logic s, input logic v, input int lim);
		t = 0;
		while (s !== v && t < lim) begin
			@(posedge clk);
			t++;
		end
		if (s !== v) begin
			errors++;
			$display("BAD wait exp %h got %h", v, s);
			end_sim();
		end
	endtask
	// ****
	// Tests
	// ****
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1;
		apb(0, ocp_pkg::ADDR_CTRL, 0);
		chk("ctrl", 32'h0000_0020, q);
		apb(0, ocp_pkg::ADDR_LS_DLY, 0);
		chk("ls_dly", 32'h03E8_03E8, q);
		apb(0, 8'h34, 32'h0000_0000);
		chk("unmapped", 32'h0000_0001, {q[30:0], err});
		chk("angle", 32'd49, 32'(ang));
		for (int k = 0; k < 8; k++) begin
			apb(1, ocp_pkg::ADDR_ANGLE, 32'(k));
			@(posedge clk);
			chk("angle", 32'(tbl[k < 7 ? k : 6]), 32'(ang));
		end
		$display("test registers done");
		for (int f = 1; f >= 0; f--) begin
			apb(1, ocp_pkg::ADDR_CTRL, 32'(f) | 32'h0000_0020);
			wt(stb, 1, 100);
			@(posedge clk);
			wt(stb, 1, 100);
			chk("period", f ? 32'd15 : 32'd19, 32'(t));
			chk("f60", 32'(f), 32'(f60));
		end
		ce <= 0;
		t = 0;
		repeat (40) begin
			@(posedge clk);
			t += stb;
		end
		ce <= 1;
		chk("freeze", 0, t);
		apb(1, ocp_pkg::ADDR_CTRL, 32'h0000_0022);
		@(posedge clk);
		chk("sin_locked", 0, 32'(esin));
		apb(1, ocp_pkg::ADDR_KEY, 32'h0000_1234);
		apb(1, ocp_pkg::ADDR_CTRL, 32'h0000_0022);
		apb(1, ocp_pkg::ADDR_CTRL, 32'h0000_0026);
		@(posedge clk);
		chk("sin_resist", 32'h0000_0003, {30'h0, eres, esin});
		$display("test settings done");
		apb(1, ocp_pkg::ADDR_LS_DLY, 32'h0005_0005);
		for (int d = 0; d < 2; d++) begin
			fwd <= d[0];
			amp <= 200;
			wt(ls_tr, 1, 200);
			chk("ls_al", 1, 32'(ls_al));
			chk("ls_time", 1, 32'(t > 39 && t < 71));
			if (d == 1) begin
				wt(bf, 1, 1300);
				chk("bf_time", 1, 32'(t > 979 && t < 1021));
			end
			amp <= 0;
			wt(ls_tr, 0, 20);
			chk("ls_clear", 0, {bf, ls_tr});
		end
		apb(1, ocp_pkg::ADDR_LS_DLY, 0);
		amp <= 200;
		repeat (200) @(posedge clk);
		chk("ls_range", 32'h0000_0002, {ls_al, ls_tr});
		apb(1, ocp_pkg::ADDR_HS_DLY, 32'h0005_0005);
		blk <= 1;
		amp <= 600;
		repeat (20) @(posedge clk);
		chk("hs_block", 0, 32'(hs_al));
		blk <= 0;
		wt(hs_al, 1, 20);
		chk("hs_free", 1, 32'(hs_al));
		wt(hs_tr, 1, 100);
		chk("hs_trip", 1, 32'(hs_tr));
		amp <= 0;
		apb(1, ocp_pkg::ADDR_HS_PICK, 0);
		amp <= 600;
		repeat (20) @(posedge clk);
		chk("hs_range", 0, 32'(hs_al));
		amp <= 0;
		$display("test phase done");
		apb(1, ocp_pkg::ADDR_E_DLY, 32'h0005_0005);
		cur_e <= 20000;
		repeat (20) @(posedge clk);
		chk("e_novolt", 0, 32'(e_al));
		resv <= 50;
		repeat (200) @(posedge clk);
		chk("e_warn", 32'h0000_0002, {e_al, e_tr});
		cur_e <= 0;
		apb(1, ocp_pkg::ADDR_CTRL, 32'h0000_0028);
		cur_e <= 20000;
		wt(e_tr, 1, 200);
		chk("e_trip", 1, 32'(e_tr));
		cur_e <= 0;
		apb(1, ocp_pkg::ADDR_LS_CFG, 32'h0000_0001);
		apb(1, ocp_pkg::ADDR_E_CFG, 32'h000A_0001);
		wt(lfl, 1, 3000);
		chk("ls_flash", 1, 32'(lfl));
		wt(efl, 1, 20);
		chk("e_flash", 1, 32'(efl));
		repeat (600) @(posedge clk);
		chk("flash_end", 0, {lfl, efl});
		apb(0, ocp_pkg::ADDR_LS_DLY, 0);
		chk("fastest", 32'h0032_0032, q);
		apb(0, ocp_pkg::ADDR_E_DLY, 0);
		chk("e_fastest", 32'h0005_0032, q);
		$display("test earth and reminder done");
		end_sim();
	end
endmodule
`default_nettype wire

// File: test/ocp_trip_logic_props.sv
`timescale 1ns/10ps
`default_nettype none
module ocp_trip_logic_props (
	input wire logic I_REF_CLK,
	input wire logic I_RST_N,
	input wire logic I_CE,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic [15:0] I_CUR_L1,
	input wire logic [15:0] I_CUR_L2,
	input wire logic [15:0] I_CUR_L3,
	input wire logic [15:0] I_RES_VOLT,
	input wire logic O_PREADY,
	input wire logic O_PSLVERR,
	input wire logic O_E_ALARM,
	input wire logic O_E_TRIP,
	input wire logic O_LS_TRIP,
	input wire logic O_HS_TRIP,
	input wire logic O_BF_RELAY,
	input wire logic O_TRIP_STORE,
	input wire logic O_SAMPLE_STB,
	input wire logic [6:0] O_CHAR_ANGLE
);
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N);
	AST_PREADY: assert property (O_PREADY) else $error("pready low");
	AST_ERR_PHASE: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE)
		else $error("error outside access");
	AST_ANGLE: assert property (O_CHAR_ANGLE inside {15, 27, 38, 49, 61, 72, 83})
		else $error("angle off list");
	AST_STORE_PULSE: assert property (O_TRIP_STORE |=> !O_TRIP_STORE)
		else $error("store pulse too long");
	AST_STORE_CAUSE: assert property (O_TRIP_STORE |-> ##[0:1] (O_LS_TRIP || O_HS_TRIP || O_E_TRIP))
		else $error("store without trip");
	AST_BF_CAUSE: assert property ($rose(O_BF_RELAY) |-> $past(I_CUR_L1 | I_CUR_L2 | I_CUR_L3) != 0)
		else $error("breaker relay without current");
	AST_BF_CLEAR: assert property ((I_CE && (I_CUR_L1 | I_CUR_L2 | I_CUR_L3) == 0)[*3] |-> !O_BF_RELAY)
		else $error("breaker relay stuck");
	AST_SAMPLE_GAP: assert property (O_SAMPLE_STB |=> !O_SAMPLE_STB [*8])
		else $error("sample strobes too close");
	AST_E_VOLT: assert property ($rose(O_E_ALARM || O_E_TRIP) |-> $past(I_RES_VOLT) != 0)
		else $error("earth fault without voltage");
endmodule
bind ocp_trip_logic ocp_trip_logic_props ocp_trip_logic_props_i (
	.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .I_CUR_L1(I_CUR_L1), .I_CUR_L2(I_CUR_L2), .I_CUR_L3(I_CUR_L3),
	.I_RES_VOLT(I_RES_VOLT), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
	.O_E_ALARM(O_E_ALARM), .O_E_TRIP(O_E_TRIP), .O_LS_TRIP(O_LS_TRIP),
	.O_HS_TRIP(O_HS_TRIP), .O_BF_RELAY(O_BF_RELAY), .O_TRIP_STORE(O_TRIP_STORE),
	.O_SAMPLE_STB(O_SAMPLE_STB), .O_CHAR_ANGLE(O_CHAR_ANGLE));
`default_nettype wire
